// File: hdl/tbs_map.svh
// register offsets, field positions and codes of the timer block sequencer
// How it works
// - group b sequencer runs four slots, two on the fast prescaler, overflow timer before count timer.
// - group a sequencer runs eight slots, four on the fast prescaler: core, lower, upper, capture.
// - within each group, timers and the capture/reload register are each handled in their own slot, never at once.
// - every scheduled action finishes within one basic cycle, one full sequencer round, except the delayed lower aux reload.
// - lower or upper aux timer reloads the core timer on each core overflow or underflow.
// - lower aux reload lands one basic cycle late with fast group a prescaler and prescale zero.
// - upper aux reload never takes the extra cycle, even at the fastest setting.
// - counting up, a read right after overflow may show zero or one before the reload lands.
// - counting down, a read right after underflow may show all-ones or all-ones minus one.
// - the late lower aux reload stretches the wrap period, interrupt spacing and toggle output by one basic cycle; other settings stay cycle exact.
// - count timer counting overflow timer wraps shows no transient values.
// - the core timer raises an interrupt request on every overflow and underflow.
`ifndef TBS_MAP_SVH
`define TBS_MAP_SVH
`define TBS_TW 16
`define TBS_PW 8
`define TBS_AW 8
`define TBS_ADR_CTRL_A 8'h00
`define TBS_ADR_CTRL_B 8'h04
`define TBS_ADR_CORE 8'h08
`define TBS_ADR_LOWER 8'h0c
`define TBS_ADR_UPPER 8'h10
`define TBS_ADR_CNT_E 8'h14
`define TBS_ADR_OVF_F 8'h18
`define TBS_ADR_CAPREG 8'h1c
`define TBS_ADR_STATUS 8'h20
`define TBS_ADR_MASK 8'h24
// control a fields
`define TBS_CA_BPS 1:0
`define TBS_CA_PSEL 4:2
`define TBS_CA_DOWN 5
`define TBS_CA_RUN 6
`define TBS_CA_RLD_EN 7
`define TBS_CA_RLD_UP 8
`define TBS_CA_CAP 9
// control b fields
`define TBS_CB_BPS 1:0
`define TBS_CB_F_RUN 2
`define TBS_CB_F_CNT 3
`define TBS_CB_F_DOWN 4
`define TBS_CB_F_RLD 5
`define TBS_CB_E_MODE 7:6
`define TBS_BPS_FAST 2'h1
`define TBS_E_TIMER 2'h1
`define TBS_E_INPUT 2'h2
`define TBS_E_WRAPS 2'h3
`define TBS_ST_CORE 0
`define TBS_ST_OVF 1
`define TBS_ST_CNT 2
`define TBS_A_SLOTS 8
`define TBS_B_SLOTS 4
`endif

// File: hdl/tbs_pkg.sv
// types of the timer block sequencer
package tbs_pkg;
   typedef enum logic [2:0] {A_CORE, A_LOWER, A_UPPER, A_CAPT, A_IDLE4, A_IDLE5, A_IDLE6,
                             A_IDLE7} tbs_a_slot_t;
   typedef enum logic [1:0] {B_OVF, B_CNT, B_IDLE2, B_IDLE3} tbs_b_slot_t;
   typedef struct packed {
      logic [2:0] slot;
   } tbs_seq_st_t;
   typedef struct packed {
      logic [1:0] bps_a;
      logic [2:0] psel;
      logic core_down;
      logic core_run;
      logic rld_en;
      logic rld_up;
      logic cap_req;
      logic [1:0] bps_b;
      logic f_run;
      logic f_cnt;
      logic f_down;
      logic f_rld;
      logic [1:0] e_mode;
      logic [15:0] core;
      logic [15:0] lower;
      logic [15:0] upper;
      logic [15:0] cnt_e;
      logic [15:0] ovf_f;
      logic [15:0] capreg;
      logic [7:0] pre;
      logic pend_lo;
      logic pend_up;
      logic pend_dly;
      logic pend_e;
      logic edge_e;
      logic edge_f;
      logic in_e_q;
      logic in_f_q;
      logic toggle;
      logic [2:0] sts;
      logic [2:0] mask;
      logic [31:0] rdata;
   } tbs_st_t;
endpackage

// File: hdl/tbs_seq.sv
// slot sequencer of one timer group, full or half length round
module tbs_seq #(
   parameter int SLOTS = 8
) (
   input wire logic clk_sys,      // system clock
   input wire logic sys_rst,      // async reset, high
   input wire logic fast,         // fast prescaler, half round
   output logic [2:0] slot,       // current slot
   output logic round_end         // last slot of the round
);
   localparam logic [2:0] LAST_FULL = 3'(SLOTS - 1);
   localparam logic [2:0] LAST_FAST = 3'(SLOTS / 2 - 1);
   tbs_pkg::tbs_seq_st_t s, n;

   // >= so a switch to fast mid round cannot leave the slot beyond the end
   always_comb begin
      n = s;
      round_end = s.slot >= (fast ? LAST_FAST : LAST_FULL);
      n.slot = round_end ? 3'h0 : s.slot + 3'h1;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign slot = s.slot;
endmodule

// File: hdl/tbs_timer_block_sequencer.sv
// two timer groups serviced slot by slot, with register port and interrupt
//
// The strobed register port and the address map are this design's own decisions.
`include "tbs_map.svh"
module tbs_timer_block_sequencer (
   input wire logic clk_sys,                   // system clock, 100 MHz
   input wire logic sys_rst,                   // async reset, high
   input wire logic [`TBS_AW-1:0] reg_addr,    // register byte address
   input wire logic [31:0] reg_wdata,          // write data
   input wire logic reg_wr,                    // write strobe
   input wire logic reg_rd,                    // read strobe
   output logic [31:0] reg_rdata,              // read data, cycle after strobe
   output logic irq,                           // level interrupt
   output logic core_timer_toggle_out,         // toggles on core wrap
   input wire logic group_b_count_input_e,     // count input of count timer
   input wire logic group_b_count_input_f,     // count input of overflow timer
   input wire logic group_b_dir_input_e,       // count timer down when high, in input count mode only
   input wire logic group_b_dir_input_f        // overflow timer down when high, when it counts its input
);
   tbs_pkg::tbs_st_t s, n;
   logic [2:0] slot_a, slot_b_raw;
   logic round_a, round_b;
   tbs_pkg::tbs_a_slot_t slot_a_e;
   tbs_pkg::tbs_b_slot_t slot_b_e;
   logic fast_a, fast_b, tick_a, wrap_a, wrap_f, wrap_e, step_f, step_e, dn_f, dn_e;
   logic [`TBS_PW-1:0] pmask;
   logic [2:0] sts_set, sts_clr;
   logic wr_core, wr_ovf, wr_cnt;

   // group a runs the long round, group b the short one
   tbs_seq #(.SLOTS(`TBS_A_SLOTS)) u_seq_a (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .fast(fast_a),
      .slot(slot_a),
      .round_end(round_a)
   );

   tbs_seq #(.SLOTS(`TBS_B_SLOTS)) u_seq_b (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .fast(fast_b),
      .slot(slot_b_raw),
      .round_end(round_b)
   );

   assign slot_a_e = tbs_pkg::tbs_a_slot_t'(slot_a);
   assign slot_b_e = tbs_pkg::tbs_b_slot_t'(slot_b_raw[1:0]);
   assign fast_a = s.bps_a == `TBS_BPS_FAST;
   assign fast_b = s.bps_b == `TBS_BPS_FAST;
   assign wr_core = reg_wr && reg_addr == `TBS_ADR_CORE;
   assign wr_ovf = reg_wr && reg_addr == `TBS_ADR_OVF_F;
   assign wr_cnt = reg_wr && reg_addr == `TBS_ADR_CNT_E;

   // next state: group a slots, group b slots, then software writes on top
   always_comb begin
      n = s;
      sts_set = 3'h0;
      wrap_a = 1'b0;
      wrap_f = 1'b0;
      wrap_e = 1'b0;
      pmask = (`TBS_PW'(1) << s.psel) - `TBS_PW'(1);
      // prescale counts whole basic cycles, so a tick always spans one round
      tick_a = s.core_run && ((s.pre & pmask) == '0);
      if (round_a) begin
         n.pre = s.pre + `TBS_PW'(1);
      end
      dn_f = s.f_cnt ? group_b_dir_input_f : s.f_down;
      dn_e = s.e_mode == `TBS_E_INPUT && group_b_dir_input_e;
      step_f = s.f_run && (!s.f_cnt || s.edge_f);
      step_e = s.e_mode == `TBS_E_TIMER || (s.e_mode == `TBS_E_INPUT && s.edge_e) ||
               (s.e_mode == `TBS_E_WRAPS && s.pend_e);
      // each element owns one slot, so interactions resolve in a fixed order
      unique case (slot_a_e)
         tbs_pkg::A_CORE: begin
            if (s.pend_dly) begin
               n.pend_dly = 1'b0;
               n.pend_lo = 1'b1;
            end
            if (tick_a) begin
               wrap_a = s.core_down ? (s.core == '0) : (&s.core);
               // wrap value stays readable until the reload slot
               n.core = s.core_down ? s.core - `TBS_TW'(1) : s.core + `TBS_TW'(1);
               if (wrap_a) begin
                  n.toggle = !s.toggle;
                  sts_set[`TBS_ST_CORE] = 1'b1;
                  if (s.rld_en) begin
                     if (s.rld_up) begin
                        n.pend_up = 1'b1;
                     end else if (fast_a && s.psel == 3'h0) begin
                        n.pend_dly = 1'b1;
                     end else begin
                        n.pend_lo = 1'b1;
                     end
                  end
               end
            end
         end
         tbs_pkg::A_LOWER: begin
            if (s.pend_lo) begin
               n.core = s.lower;
               n.pend_lo = 1'b0;
            end
         end
         tbs_pkg::A_UPPER: begin
            if (s.pend_up) begin
               n.core = s.upper;
               n.pend_up = 1'b0;
            end
         end
         tbs_pkg::A_CAPT: begin
            if (s.cap_req) begin
               n.lower = s.core;
               n.cap_req = 1'b0;
            end
         end
         tbs_pkg::A_IDLE4, tbs_pkg::A_IDLE5, tbs_pkg::A_IDLE6, tbs_pkg::A_IDLE7: begin
         end
      endcase
      // overflow timer first, so the count timer sees its wrap next slot
      unique case (slot_b_e)
         tbs_pkg::B_OVF: begin
            n.edge_f = 1'b0;
            if (step_f) begin
               wrap_f = dn_f ? (s.ovf_f == '0) : (&s.ovf_f);
               n.ovf_f = dn_f ? s.ovf_f - `TBS_TW'(1) : s.ovf_f + `TBS_TW'(1);
               if (wrap_f) begin
                  sts_set[`TBS_ST_OVF] = 1'b1;
                  if (s.f_rld) begin
                     n.ovf_f = s.capreg;
                  end
                  if (s.e_mode == `TBS_E_WRAPS) begin
                     n.pend_e = 1'b1;
                  end
               end
            end
         end
         tbs_pkg::B_CNT: begin
            n.edge_e = 1'b0;
            n.pend_e = 1'b0;
            if (step_e) begin
               wrap_e = dn_e ? (s.cnt_e == '0) : (&s.cnt_e);
               n.cnt_e = dn_e ? s.cnt_e - `TBS_TW'(1) : s.cnt_e + `TBS_TW'(1);
               if (wrap_e) begin
                  sts_set[`TBS_ST_CNT] = 1'b1;
               end
            end
         end
         tbs_pkg::B_IDLE2, tbs_pkg::B_IDLE3: begin
         end
      endcase
      // edges caught after the slot clears them, so a new edge is never lost
      n.in_e_q = group_b_count_input_e;
      n.in_f_q = group_b_count_input_f;
      if (group_b_count_input_e && !s.in_e_q) begin
         n.edge_e = 1'b1;
      end
      if (group_b_count_input_f && !s.in_f_q) begin
         n.edge_f = 1'b1;
      end
      // software writes win over hardware updates of the same register, except status, where a hardware set beats the clear
      sts_clr = 3'h0;
      if (reg_wr) begin
         unique case (reg_addr)
            `TBS_ADR_CTRL_A: begin
               n.bps_a = reg_wdata[`TBS_CA_BPS];
               n.psel = reg_wdata[`TBS_CA_PSEL];
               n.core_down = reg_wdata[`TBS_CA_DOWN];
               n.core_run = reg_wdata[`TBS_CA_RUN];
               n.rld_en = reg_wdata[`TBS_CA_RLD_EN];
               n.rld_up = reg_wdata[`TBS_CA_RLD_UP];
               n.cap_req = reg_wdata[`TBS_CA_CAP];
            end
            `TBS_ADR_CTRL_B: begin
               n.bps_b = reg_wdata[`TBS_CB_BPS];
               n.f_run = reg_wdata[`TBS_CB_F_RUN];
               n.f_cnt = reg_wdata[`TBS_CB_F_CNT];
               n.f_down = reg_wdata[`TBS_CB_F_DOWN];
               n.f_rld = reg_wdata[`TBS_CB_F_RLD];
               n.e_mode = reg_wdata[`TBS_CB_E_MODE];
            end
            `TBS_ADR_CORE: n.core = reg_wdata[`TBS_TW-1:0];
            `TBS_ADR_LOWER: n.lower = reg_wdata[`TBS_TW-1:0];
            `TBS_ADR_UPPER: n.upper = reg_wdata[`TBS_TW-1:0];
            `TBS_ADR_CNT_E: n.cnt_e = reg_wdata[`TBS_TW-1:0];
            `TBS_ADR_OVF_F: n.ovf_f = reg_wdata[`TBS_TW-1:0];
            `TBS_ADR_CAPREG: n.capreg = reg_wdata[`TBS_TW-1:0];
            `TBS_ADR_STATUS: sts_clr = reg_wdata[2:0];
            `TBS_ADR_MASK: n.mask = reg_wdata[2:0];
            default: begin
            end
         endcase
      end
      // set beats a write-one clear in the same cycle
      n.sts = (s.sts & ~sts_clr) | sts_set;
      // read data stands only in the cycle after the strobe
      n.rdata = 32'h0;
      if (reg_rd) begin
         unique case (reg_addr)
            `TBS_ADR_CTRL_A: n.rdata = {22'h0, s.cap_req, s.rld_up, s.rld_en, s.core_run,
                                        s.core_down, s.psel, s.bps_a};
            `TBS_ADR_CTRL_B: n.rdata = {24'h0, s.e_mode, s.f_rld, s.f_down, s.f_cnt, s.f_run,
                                        s.bps_b};
            `TBS_ADR_CORE: n.rdata = {16'h0, s.core};
            `TBS_ADR_LOWER: n.rdata = {16'h0, s.lower};
            `TBS_ADR_UPPER: n.rdata = {16'h0, s.upper};
            `TBS_ADR_CNT_E: n.rdata = {16'h0, s.cnt_e};
            `TBS_ADR_OVF_F: n.rdata = {16'h0, s.ovf_f};
            `TBS_ADR_CAPREG: n.rdata = {16'h0, s.capreg};
            `TBS_ADR_STATUS: n.rdata = {29'h0, s.sts};
            `TBS_ADR_MASK: n.rdata = {29'h0, s.mask};
            default: n.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // outputs straight from flops, interrupt from status and mask
   assign reg_rdata = s.rdata;
   assign core_timer_toggle_out = s.toggle;
   assign irq = |(s.sts & s.mask);

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   property p_a_round;
      (!fast_a && slot_a == 3'h7) |=> slot_a == 3'h0;
   endproperty
   a_a_round: assert property (p_a_round) else $error("group a round not eight slots");

   property p_b_fast;
      (fast_b && slot_b_raw == 3'h1) |=> slot_b_raw == 3'h0;
   endproperty
   a_b_fast: assert property (p_b_fast) else $error("group b fast round not two slots");

   property p_core_slots;
      (!reg_wr && !(slot_a_e inside {tbs_pkg::A_CORE, tbs_pkg::A_LOWER, tbs_pkg::A_UPPER}))
         |=> $stable(s.core);
   endproperty
   a_core_slots: assert property (p_core_slots) else $error("core changed outside its slots");

   property p_lo_done;
      $rose(s.pend_lo) |-> ##[1:8] !s.pend_lo;
   endproperty
   a_lo_done: assert property (p_lo_done) else $error("lower reload not done in one round");

   property p_dly;
      (wrap_a && s.rld_en && !s.rld_up && fast_a && s.psel == 3'h0 && !reg_wr)
         |=> s.pend_dly && !s.pend_lo;
   endproperty
   a_dly: assert property (p_dly) else $error("fast lower reload not delayed");

   property p_up_reload;
      (wrap_a && s.rld_en && s.rld_up && !reg_wr) ##1 (!reg_wr) [*2] |=> s.core == $past(s.upper);
   endproperty
   a_up_reload: assert property (p_up_reload) else $error("upper reload not on time");

   property p_up_zero;
      (wrap_a && !s.core_down && !reg_wr) |=> s.core == '0;
   endproperty
   a_up_zero: assert property (p_up_zero) else $error("overflow did not pass zero");

   property p_toggle;
      wrap_a |=> core_timer_toggle_out != $past(core_timer_toggle_out);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle output missed a wrap");

   property p_e_count;
      (wrap_f && s.e_mode == `TBS_E_WRAPS && !reg_wr) ##1 !reg_wr |=>
         s.cnt_e == $past(s.cnt_e) + `TBS_TW'(1);
   endproperty
   a_e_count: assert property (p_e_count) else $error("count timer missed a wrap");

   property p_irq_set;
      wrap_a |=> s.sts[`TBS_ST_CORE];
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("core wrap did not set status");

   // slot order, reload landing, underflow value, status clear and ownership of each counter by its own slot
   property p_a_fast;
      (fast_a && slot_a_e == tbs_pkg::A_CAPT) |=> slot_a == 3'h0;
   endproperty
   a_a_fast: assert property (p_a_fast) else $error("group a fast round not four slots");

   property p_b_order;
      (slot_b_e == tbs_pkg::B_OVF) |=> slot_b_e == tbs_pkg::B_CNT;
   endproperty
   a_b_order: assert property (p_b_order) else $error("count timer not after overflow timer");

   property p_b_round;
      (!fast_b && slot_b_raw == 3'h3) |=> slot_b_raw == 3'h0;
   endproperty
   a_b_round: assert property (p_b_round) else $error("group b round not four slots");

   property p_lo_reload;
      (wrap_a && s.rld_en && !s.rld_up && !(fast_a && s.psel == 3'h0) && !reg_wr) ##1 !reg_wr
         |=> s.core == $past(s.lower);
   endproperty
   a_lo_reload: assert property (p_lo_reload) else $error("lower reload not on time");

   property p_dly_late;
      (s.pend_dly && slot_a_e == tbs_pkg::A_CORE && !reg_wr) ##1 !reg_wr
         |=> s.core == $past(s.lower);
   endproperty
   a_dly_late: assert property (p_dly_late) else $error("delayed reload did not land");

   property p_dn_ones;
      (wrap_a && s.core_down && !reg_wr) |=> s.core == '1;
   endproperty
   a_dn_ones: assert property (p_dn_ones) else $error("underflow did not pass all ones");

   property p_irq_clr;
      (reg_wr && reg_addr == `TBS_ADR_STATUS && reg_wdata[`TBS_ST_CORE] && !wrap_a)
         |=> !s.sts[`TBS_ST_CORE];
   endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("core status not cleared");

   property p_cap_slot;
      (!reg_wr && slot_a_e != tbs_pkg::A_CAPT) |=> $stable(s.lower);
   endproperty
   a_cap_slot: assert property (p_cap_slot) else $error("lower changed outside capture");

   property p_ovf_slot;
      (!reg_wr && slot_b_e != tbs_pkg::B_OVF) |=> $stable(s.ovf_f);
   endproperty
   a_ovf_slot: assert property (p_ovf_slot) else $error("overflow timer out of slot");

   property p_cnt_slot;
      (!reg_wr && slot_b_e != tbs_pkg::B_CNT) |=> $stable(s.cnt_e);
   endproperty
   a_cnt_slot: assert property (p_cnt_slot) else $error("count timer out of slot");

   property p_up_done;
      $rose(s.pend_up) |-> ##[1:8] !s.pend_up;
   endproperty
   a_up_done: assert property (p_up_done) else $error("upper reload not done in one round");
endmodule

// File: bench/tbs_timer_block_sequencer_tb.sv
// self-checking bench of the timer block sequencer over its register port
`include "tbs_map.svh"
module tbs_timer_block_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic irq;
   logic core_timer_toggle_out;
   logic in_e = 1'b0;
   logic in_f = 1'b0;
   logic dir_e = 1'b0;
   logic dir_f = 1'b0;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   int n;
   logic [31:0] d;

   tbs_timer_block_sequencer tbs_timer_block_sequencer_inst (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .irq(irq),
      .core_timer_toggle_out(core_timer_toggle_out),
      .group_b_count_input_e(in_e),
      .group_b_count_input_f(in_f),
      .group_b_dir_input_e(dir_e),
      .group_b_dir_input_f(dir_f)
   );

   // 100 mhz system clock
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   task wrap_up;
      if (miscompares == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // hang guard, about fifteen times the expected run length
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         miscompares++;
         wrap_up();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one-cycle write strobe
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      chk(v, exp);
   endtask

   // cycles until the toggle output changes, sampled after each edge settles
   task tgl(output int c);
      logic t0;
      t0 = core_timer_toggle_out;
      c = 0;
      do begin
         @(posedge clk_sys);
         #1 c++;
      end while (core_timer_toggle_out === t0 && c < 3000);
   endtask

   // both aux timers hold the same value, so only the reload timing differs
   task per_run(input logic [8:0] cfg, input logic [15:0] r, input logic [31:0] exp);
      wr(`TBS_ADR_CTRL_A, 32'h0);
      wr(`TBS_ADR_CORE, {16'h0, r});
      wr(`TBS_ADR_LOWER, {16'h0, r});
      wr(`TBS_ADR_UPPER, {16'h0, r});
      wr(`TBS_ADR_CTRL_A, {23'h0, cfg});
      tgl(n);
      tgl(n);
      chk(n, exp);
   endtask

   // edges held eight cycles per level, longer than a group b round
   task pulse(input int k);
      repeat (k) begin
         @(posedge clk_sys);
         in_e <= 1'b0;
         in_f <= 1'b0;
         repeat (8) @(posedge clk_sys);
         in_e <= 1'b1;
         in_f <= 1'b1;
         repeat (8) @(posedge clk_sys);
      end
   endtask

   initial begin
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      // every register clears on reset
      for (int a = 0; a <= 8'h24; a += 4)
         rd_chk(a[7:0], 32'h0);
      rd_chk(8'h30, 32'h0);
      wr(8'h30, 32'hffff_ffff);
      rd_chk(8'h30, 32'h0);
      // capture slot copies core into lower aux, upper bits read zero
      wr(`TBS_ADR_CORE, 32'hffff_5a5a);
      rd_chk(`TBS_ADR_CORE, 32'h0000_5a5a);
      wr(`TBS_ADR_CTRL_A, 32'h200);
      repeat (16) @(posedge clk_sys);
      rd_chk(`TBS_ADR_LOWER, 32'h0000_5a5a);
      rd_chk(`TBS_ADR_CTRL_A, 32'h0);
      // wrap period in cycles: rounds of 8, or 4 on the fast prescaler
      per_run(9'h1c1, 16'hfff0, 32'd64);
      per_run(9'h0c1, 16'hfff0, 32'd68);
      per_run(9'h0c0, 16'hfff0, 32'd128);
      per_run(9'h0c5, 16'hfff0, 32'd128);
      per_run(9'h1e1, 16'h000f, 32'd64);
      per_run(9'h0e1, 16'h000f, 32'd68);
      per_run(9'h1c4, 16'hfff0, 32'd256);
      wr(`TBS_ADR_CTRL_A, 32'h0);
      // status sticky, irq only when masked
      rd_chk(`TBS_ADR_STATUS, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(`TBS_ADR_MASK, 32'h1);
      #1 chk({31'h0, irq}, 32'h1);
      wr(`TBS_ADR_STATUS, 32'h1);
      #1 chk({31'h0, irq}, 32'h0);
      rd_chk(`TBS_ADR_STATUS, 32'h0);
      // count timer steps once per group b round, from ffff through wrap, then from zero on the fast prescaler
      wr(`TBS_ADR_CNT_E, 32'hffff);
      wr(`TBS_ADR_CTRL_B, 32'h40);
      repeat (38) @(posedge clk_sys);
      wr(`TBS_ADR_CTRL_B, 32'h0);
      rd_chk(`TBS_ADR_CNT_E, 32'h9);
      wr(`TBS_ADR_CNT_E, 32'h0);
      wr(`TBS_ADR_CTRL_B, 32'h41);
      repeat (38) @(posedge clk_sys);
      wr(`TBS_ADR_CTRL_B, 32'h0);
      rd_chk(`TBS_ADR_CNT_E, 32'h14);
      // count timer counts overflow timer wraps, no transient value
      wr(`TBS_ADR_OVF_F, 32'hfffe);
      wr(`TBS_ADR_CNT_E, 32'h0);
      wr(`TBS_ADR_CTRL_B, 32'hc4);
      repeat (62) @(posedge clk_sys);
      wr(`TBS_ADR_CTRL_B, 32'h0);
      rd_chk(`TBS_ADR_CNT_E, 32'h1);
      rd_chk(`TBS_ADR_OVF_F, 32'h000e);
      rd_chk(`TBS_ADR_STATUS, 32'h6);
      wr(`TBS_ADR_MASK, 32'h4);
      #1 chk({31'h0, irq}, 32'h1);
      wr(`TBS_ADR_STATUS, 32'h6);
      // edge counting stays on the slow group b prescaler
      wr(`TBS_ADR_CNT_E, 32'h0);
      wr(`TBS_ADR_OVF_F, 32'h0);
      wr(`TBS_ADR_CTRL_B, 32'h8c);
      pulse(5);
      @(posedge clk_sys);
      dir_e <= 1'b1;
      dir_f <= 1'b1;
      repeat (8) @(posedge clk_sys);
      pulse(2);
      wr(`TBS_ADR_CTRL_B, 32'h0);
      rd_chk(`TBS_ADR_CNT_E, 32'h3);
      rd_chk(`TBS_ADR_OVF_F, 32'h3);
      chk({31'h0, irq}, 32'h0);
      wrap_up();
   end
endmodule
